//--- logic/sos_pkg.sv
// Purpose: Constants and types for the status output selector
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes:   Summary of operation below
//
// Summary of operation
// - Each digital output has own selection code
// - Code 00 asserts while motor runs
// - Code 01 asserts while reference frequency reached
// - Code 02 asserts above ramp-direction frequency threshold
// - Code 03 asserts above overload warning threshold
// - Code 04 asserts above PID deviation limit
// - Code 05 asserts while drive faulted
// - Code 06 flags reference loss, run only
// - Code 07 flags feedback outside band, run only
// - Code 08 flags watchdog expiry; fault/warning selectable
// - Code 09 shows AND/OR/XOR logic link result
// - Code 10 flags fieldbus supply fault
// - Relay normal pair closed unless fault/unpowered, when relay code is 05
// - Relay has own selection, signal or output
// - Meter shows frequency, or current when selected
package sos_pkg;

    localparam int          ADDR_W          = 7;
    localparam int          VAL_W           = 16;
    localparam int          NUM_COND        = 11;
    localparam int          N_CFG           = 13;

    // Byte offsets of the registers
    localparam logic [6:0]  OFS_OUT1_SEL    = 7'h00;
    localparam logic [6:0]  OFS_OUT2_SEL    = 7'h04;
    localparam logic [6:0]  OFS_RELAY_SEL   = 7'h08;
    localparam logic [6:0]  OFS_METER_SEL   = 7'h0C;
    localparam logic [6:0]  OFS_OVL_THR     = 7'h10;
    localparam logic [6:0]  OFS_ACC_THR     = 7'h14;
    localparam logic [6:0]  OFS_DEC_THR     = 7'h18;
    localparam logic [6:0]  OFS_PID_LIM     = 7'h1C;
    localparam logic [6:0]  OFS_FB_UPPER    = 7'h20;
    localparam logic [6:0]  OFS_FB_LOWER    = 7'h24;
    localparam logic [6:0]  OFS_VREF_LOSS   = 7'h28;
    localparam logic [6:0]  OFS_WD_ACTION   = 7'h2C;
    localparam logic [6:0]  OFS_LOGIC_CFG   = 7'h30;
    localparam logic [6:0]  OFS_COND_STAT   = 7'h34;
    localparam logic [6:0]  OFS_IRQ_STAT    = 7'h38;
    localparam logic [6:0]  OFS_IRQ_EN      = 7'h3C;
    localparam logic [6:0]  OFS_IRQ_CLR     = 7'h40;

    // Config array indices (byte offset / 4)
    localparam logic [3:0]  IDX_OUT1        = 4'h0;
    localparam logic [3:0]  IDX_OUT2        = 4'h1;
    localparam logic [3:0]  IDX_RELAY       = 4'h2;
    localparam logic [3:0]  IDX_METER       = 4'h3;
    localparam logic [3:0]  IDX_OVL         = 4'h4;
    localparam logic [3:0]  IDX_ACC         = 4'h5;
    localparam logic [3:0]  IDX_DEC         = 4'h6;
    localparam logic [3:0]  IDX_PID         = 4'h7;
    localparam logic [3:0]  IDX_FBU         = 4'h8;
    localparam logic [3:0]  IDX_FBL         = 4'h9;
    localparam logic [3:0]  IDX_VREF        = 4'hA;
    localparam logic [3:0]  IDX_WD          = 4'hB;
    localparam logic [3:0]  IDX_LOGIC       = 4'hC;

    // Selection codes, also bit positions of the condition vector
    localparam logic [7:0]  CODE_RUN        = 8'h00;
    localparam logic [7:0]  CODE_FREQ_REACH = 8'h01;
    localparam logic [7:0]  CODE_FREQ_THR   = 8'h02;
    localparam logic [7:0]  CODE_OVERLOAD   = 8'h03;
    localparam logic [7:0]  CODE_PID_DEV    = 8'h04;
    localparam logic [7:0]  CODE_FAULT      = 8'h05;
    localparam logic [7:0]  CODE_REF_LOSS   = 8'h06;
    localparam logic [7:0]  CODE_FB_LOSS    = 8'h07;
    localparam logic [7:0]  CODE_WATCHDOG   = 8'h08;
    localparam logic [7:0]  CODE_LOGIC      = 8'h09;
    localparam logic [7:0]  CODE_FBUS       = 8'h0A;

    localparam logic [15:0] RST_OUT1        = 16'h0001;
    localparam logic [15:0] RST_OUT2        = 16'h0000;
    localparam logic [15:0] RST_RELAY       = 16'h0005;
    localparam logic [15:0] RST_OTHER       = 16'h0000;

    localparam logic [7:0]  METER_CURRENT   = 8'h01;
    localparam logic [7:0]  WD_AS_FAULT     = 8'h01;

    // Logic link config fields
    localparam int          LOG_OP_LSB      = 0;
    localparam int          LOG_A_LSB       = 4;
    localparam int          LOG_B_LSB       = 8;
    localparam logic [1:0]  LOG_AND         = 2'h0;
    localparam logic [1:0]  LOG_OR          = 2'h1;
    localparam logic [1:0]  LOG_XOR         = 2'h2;

    // Interrupt bits
    localparam int          IRQ_W           = 6;
    localparam int          IRQ_OVERLOAD    = 0;
    localparam int          IRQ_FAULT       = 1;
    localparam int          IRQ_REF_LOSS    = 2;
    localparam int          IRQ_FB_LOSS     = 3;
    localparam int          IRQ_WATCHDOG    = 4;
    localparam int          IRQ_FBUS        = 5;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic                    run;
        logic                    ref_freq_reached;
        logic                    accel_ramp;
        logic                    decel_ramp;
        logic                    drive_fault;
        logic                    comm_watchdog_expired;
        logic                    fieldbus_supply_fault;
        logic [VAL_W-1:0]        output_freq;
        logic [VAL_W-1:0]        motor_current;
        logic [VAL_W-1:0]        voltage_ref;
        logic [VAL_W-1:0]        current_ref_input;
        logic [VAL_W-1:0]        pid_deviation;
        logic signed [VAL_W-1:0] pid_fb_diff;
    } sos_core_type;

endpackage : sos_pkg

//--- logic/sos_status_output_selector.sv
// Purpose: Routes drive status conditions to two outputs, a relay and a meter
// Assumes: Core status inputs synchronous to aclk; AXI4-Lite master
// Notes:   Outputs lag their cause by one clock, irq_q by two
`timescale 1ns/10ps
module sos_status_output_selector
    import sos_pkg::*;
#(
    parameter logic [VAL_W-1:0] LOOP_4MA_CODE = 16'h0333
) (
    input  wire logic               aclk,           // System clock
    input  wire logic               aresetn,        // Sync reset, active low
    input  wire logic [ADDR_W-1:0]  s_awaddr,       // Write address
    input  wire logic               s_awvalid,      // Write address valid
    output logic                    s_awready,      // Write address ready
    input  wire logic [31:0]        s_wdata,        // Write data
    input  wire logic [3:0]         s_wstrb,        // Write byte strobes
    input  wire logic               s_wvalid,       // Write data valid
    output logic                    s_wready,       // Write data ready
    output logic [1:0]              s_bresp,        // Write response
    output logic                    s_bvalid,       // Write response valid
    input  wire logic               s_bready,       // Write response ready
    input  wire logic [ADDR_W-1:0]  s_araddr,       // Read address
    input  wire logic               s_arvalid,      // Read address valid
    output logic                    s_arready,      // Read address ready
    output logic [31:0]             s_rdata,        // Read data
    output logic [1:0]              s_rresp,        // Read response
    output logic                    s_rvalid,       // Read data valid
    input  wire logic               s_rready,       // Read data ready
    input  wire sos_core_type       core,           // Control core status
    output logic                    dout1_q,        // Digital output 1
    output logic                    dout2_q,        // Digital output 2
    output logic                    relay_normal_contact_q, // Normal pair closed
    output logic                    relay_fault_contact_q,  // Alternate pair closed
    output logic [VAL_W-1:0]        analog_meter_output_q,  // Meter value
    output logic                    irq_q           // Interrupt, active high
);

    function automatic logic sel_cond(input logic [7:0] code,
                                      input logic [NUM_COND-1:0] cv);
        sel_cond = (code < 8'(NUM_COND)) ? cv[code[3:0]] : 1'b0;
    endfunction : sel_cond

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction : merge

    function automatic logic [15:0] cfg_reset(input int idx);
        case (idx)
            int'(IDX_OUT1):  cfg_reset = RST_OUT1;
            int'(IDX_OUT2):  cfg_reset = RST_OUT2;
            int'(IDX_RELAY): cfg_reset = RST_RELAY;
            default:         cfg_reset = RST_OTHER;
        endcase
    endfunction : cfg_reset

    logic [15:0]            cfg_q [N_CFG];
    logic [IRQ_W-1:0]       irq_stat_q;
    logic [IRQ_W-1:0]       irq_en_q;
    logic [IRQ_W-1:0]       ev_prev_q;
    logic [ADDR_W-1:0]      awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   aw_got_q;
    logic                   w_got_q;

    // Condition vector, bit n is selection code n
    wire logic [NUM_COND-1:0] cond_w;
    wire logic [NUM_COND-1:0] base_w;
    wire logic              wd_fault_w;
    wire logic              fault_w;
    wire logic              freq_thr_w;
    wire logic              ref_loss_w;
    wire logic              fb_loss_w;
    wire logic              log_a_w;
    wire logic              log_b_w;
    wire logic [1:0]        log_op_w;
    wire logic              log_res_w;
    wire logic [7:0]        sel1_w;
    wire logic [7:0]        sel2_w;
    wire logic [7:0]        relsel_w;
    wire logic              relay_on_w;

    assign sel1_w     = cfg_q[IDX_OUT1][7:0];
    assign sel2_w     = cfg_q[IDX_OUT2][7:0];
    assign relsel_w   = cfg_q[IDX_RELAY][7:0];
    assign wd_fault_w = core.comm_watchdog_expired && (cfg_q[IDX_WD][7:0] == WD_AS_FAULT);
    assign fault_w    = core.drive_fault || wd_fault_w;
    assign freq_thr_w = (core.accel_ramp && core.output_freq > cfg_q[IDX_ACC])
                     || (core.decel_ramp && core.output_freq > cfg_q[IDX_DEC]);
    assign ref_loss_w = core.run && (core.voltage_ref < cfg_q[IDX_VREF]
                     || core.current_ref_input < LOOP_4MA_CODE);
    assign fb_loss_w  = core.run && (core.pid_fb_diff > $signed(cfg_q[IDX_FBU])
                     || core.pid_fb_diff < $signed(cfg_q[IDX_FBL]));

    // Link operands drawn from the other conditions; the link cannot feed itself
    assign log_a_w    = (cfg_q[IDX_LOGIC][LOG_A_LSB+:4] == CODE_LOGIC[3:0]) ? 1'b0
                      : sel_cond({4'h0, cfg_q[IDX_LOGIC][LOG_A_LSB+:4]}, base_w);
    assign log_b_w    = (cfg_q[IDX_LOGIC][LOG_B_LSB+:4] == CODE_LOGIC[3:0]) ? 1'b0
                      : sel_cond({4'h0, cfg_q[IDX_LOGIC][LOG_B_LSB+:4]}, base_w);
    assign log_op_w   = cfg_q[IDX_LOGIC][LOG_OP_LSB+:2];
    assign log_res_w  = (log_op_w == LOG_AND) ? (log_a_w & log_b_w)
                      : (log_op_w == LOG_OR)  ? (log_a_w | log_b_w)
                      : (log_op_w == LOG_XOR) ? (log_a_w ^ log_b_w) : 1'b0;

    assign base_w[CODE_RUN[3:0]]        = core.run;
    assign base_w[CODE_FREQ_REACH[3:0]] = core.ref_freq_reached;
    assign base_w[CODE_FREQ_THR[3:0]]   = freq_thr_w;
    assign base_w[CODE_OVERLOAD[3:0]]   = core.motor_current > cfg_q[IDX_OVL];
    assign base_w[CODE_PID_DEV[3:0]]    = core.pid_deviation > cfg_q[IDX_PID];
    assign base_w[CODE_FAULT[3:0]]      = fault_w;
    assign base_w[CODE_REF_LOSS[3:0]]   = ref_loss_w;
    assign base_w[CODE_FB_LOSS[3:0]]    = fb_loss_w;
    assign base_w[CODE_WATCHDOG[3:0]]   = core.comm_watchdog_expired;
    assign base_w[CODE_LOGIC[3:0]]      = 1'b0;
    assign base_w[CODE_FBUS[3:0]]       = core.fieldbus_supply_fault;
    // Link result merged last, so its operands cannot loop back through it
    assign cond_w = base_w | (NUM_COND'(log_res_w) << CODE_LOGIC[3:0]);

    // Signalling mode: energised while healthy, so a dead supply reads as fault
    assign relay_on_w = (relsel_w == CODE_FAULT) ? !fault_w : sel_cond(relsel_w, cond_w);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout1_q                <= 1'b0;
            dout2_q                <= 1'b0;
            relay_normal_contact_q <= 1'b0;
            relay_fault_contact_q  <= 1'b1;
            analog_meter_output_q  <= '0;
        end else begin
            dout1_q                <= sel_cond(sel1_w, cond_w);
            dout2_q                <= sel_cond(sel2_w, cond_w);
            relay_normal_contact_q <= relay_on_w;
            relay_fault_contact_q  <= !relay_on_w;
            analog_meter_output_q  <= (cfg_q[IDX_METER][7:0] == METER_CURRENT)
                                    ? core.motor_current : core.output_freq;
        end
    end

    // Interrupt events: rising edges of the warning and fault conditions
    wire logic [IRQ_W-1:0] ev_lvl_w;
    wire logic [IRQ_W-1:0] ev_rise_w;
    wire logic             wr_fire_w;
    wire logic [4:0]       wr_idx_w;
    wire logic             wr_clr_w;

    assign ev_lvl_w  = {core.fieldbus_supply_fault, core.comm_watchdog_expired, fb_loss_w,
                        ref_loss_w, fault_w, cond_w[CODE_OVERLOAD[3:0]]};
    assign ev_rise_w = ev_lvl_w & ~ev_prev_q;
    assign wr_fire_w = aw_got_q && w_got_q && !s_bvalid;
    assign wr_idx_w  = awaddr_q[6:2];
    assign wr_clr_w  = wr_fire_w && awaddr_q == OFS_IRQ_CLR && wstrb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_prev_q  <= '0;
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            ev_prev_q  <= ev_lvl_w;
            // Set beats a clear landing in the same cycle
            irq_stat_q <= (irq_stat_q & ~(wr_clr_w ? wdata_q[IRQ_W-1:0] : '0)) | ev_rise_w;
            irq_q      <= |(irq_stat_q & irq_en_q);
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    wire logic aw_hs_w;
    wire logic w_hs_w;
    wire logic wr_map_w;

    assign aw_hs_w  = s_awvalid && s_awready;
    assign w_hs_w   = s_wvalid && s_wready;
    assign wr_map_w = (wr_idx_w < 5'(N_CFG)) || awaddr_q == OFS_IRQ_EN
                   || awaddr_q == OFS_IRQ_CLR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
        end else begin
            if (aw_hs_w) begin
                aw_got_q  <= 1'b1;
                awaddr_q  <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (w_hs_w) begin
                w_got_q  <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_fire_w) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_map_w ? RESP_OKAY : RESP_SLVERR;
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    generate
        for (genvar i = 0; i < N_CFG; i++) begin : g_cfg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg_q[i] <= cfg_reset(i);
                end else if (wr_fire_w && wr_idx_w == 5'(i)) begin
                    cfg_q[i] <= merge(cfg_q[i], wdata_q, wstrb_q);
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_q <= '0;
        end else if (wr_fire_w && awaddr_q == OFS_IRQ_EN && wstrb_q[0]) begin
            irq_en_q <= wdata_q[IRQ_W-1:0];
        end
    end

    // AXI4-Lite read path: one read at a time, answer one cycle after taking
    wire logic        ar_hs_w;
    wire logic [4:0]  rd_idx_w;
    wire logic [31:0] rd_val_w;
    wire logic        rd_map_w;

    assign ar_hs_w  = s_arvalid && s_arready;
    assign rd_idx_w = s_araddr[6:2];
    assign rd_map_w = (rd_idx_w < 5'(N_CFG)) || s_araddr == OFS_COND_STAT
                   || s_araddr == OFS_IRQ_STAT || s_araddr == OFS_IRQ_EN
                   || s_araddr == OFS_IRQ_CLR;
    assign rd_val_w = (rd_idx_w < 5'(N_CFG))       ? {16'h0000, cfg_q[rd_idx_w[3:0]]}
                    : (s_araddr == OFS_COND_STAT)  ? 32'(cond_w)
                    : (s_araddr == OFS_IRQ_STAT)   ? 32'(irq_stat_q)
                    : (s_araddr == OFS_IRQ_EN)     ? 32'(irq_en_q)
                    : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= RESP_OKAY;
        end else if (ar_hs_w) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_val_w;
            s_rresp   <= rd_map_w ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        aw_hs_w && w_hs_w;
    endsequence

    a_out1_follows: assert property (##1 dout1_q == sel_cond($past(sel1_w), $past(cond_w)))
        else $error("output 1 does not follow its selected condition");
    a_run_code: assert property (sel2_w == CODE_RUN && $stable(sel2_w) |=> dout2_q == $past(core.run))
        else $error("run code does not track run state");
    a_bad_code_low: assert property (sel2_w >= 8'(NUM_COND) |=> !dout2_q)
        else $error("out of range code drove output 2");
    a_ref_loss_stop: assert property (!core.run |-> !cond_w[CODE_REF_LOSS[3:0]] && !cond_w[CODE_FB_LOSS[3:0]])
        else $error("reference or feedback loss flagged outside run");
    a_freq_thr_idle: assert property (!core.accel_ramp && !core.decel_ramp |-> !freq_thr_w)
        else $error("frequency threshold flagged without a ramp");
    a_relay_fault: assert property (relsel_w == CODE_FAULT && fault_w |=> relay_fault_contact_q && !relay_normal_contact_q)
        else $error("relay did not drop on fault");
    a_relay_pairs: assert property (relsel_w != CODE_FAULT
        |=> relay_normal_contact_q == $past(sel_cond(relsel_w, cond_w))
            && relay_normal_contact_q != relay_fault_contact_q)
        else $error("relay as plain output does not follow its condition");
    a_meter_select: assert property (cfg_q[IDX_METER][7:0] != METER_CURRENT |=> analog_meter_output_q == $past(core.output_freq))
        else $error("meter not showing output frequency");
    a_write_resp: assert property (s_wr_taken |-> ##[1:2] s_bvalid)
        else $error("write response late");

endmodule : sos_status_output_selector

//--- tb/sos_plc_model.sv
// Purpose: PLC input card wired to both outputs and the relay pairs
// Assumes: Inputs are levels, scanned on the rising edge
// Notes:   Scan adds one cycle, so the bench waits a little longer
`timescale 1ns/10ps
module sos_plc_model (
    input  wire logic       aclk,     // Scan clock
    input  wire logic       in1,      // Output 1 terminal
    input  wire logic       in2,      // Output 2 terminal
    input  wire logic       k_norm,   // Normal contact pair
    input  wire logic       k_alt,    // Alternate contact pair
    output logic [3:0]      seen_q    // Latched inputs
);
    always_ff @(posedge aclk) begin
        seen_q <= {k_alt, k_norm, in2, in1};
    end
endmodule : sos_plc_model

//--- tb/tb_status_output_selector.sv
// Purpose: Self-checking bench for the status output selector
// Assumes: 200 MHz clock, registers over AXI4-Lite, bready/rready held high
// Notes:   Three-edge waits cover design latency plus the PLC scan
`timescale 1ns/10ps
module tb_status_output_selector
    import sos_pkg::*;
;
    logic              aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
    logic              s_bvalid, s_arvalid, s_arready, s_rvalid, dout1_q, dout2_q;
    logic              k_no, k_nc, irq_q;
    logic [ADDR_W-1:0] s_awaddr, s_araddr;
    logic [31:0]       s_wdata, s_rdata, rd;
    logic [3:0]        seen;
    logic [1:0]        s_bresp, s_rresp, rs;
    logic [VAL_W-1:0]  meter;
    sos_core_type      core;
    int                errors, checks_done;

    sos_status_output_selector dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready(1'b1),
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready(1'b1),
        .core, .dout1_q, .dout2_q, .relay_normal_contact_q(k_no),
        .relay_fault_contact_q(k_nc), .analog_meter_output_q(meter), .irq_q);
    sos_plc_model plc (.aclk, .in1(dout1_q), .in2(dout2_q), .k_norm(k_no), .k_alt(k_nc),
        .seen_q(seen));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    function automatic sos_core_type mk(input int c);
        sos_core_type k;
        k = '0;
        k.voltage_ref = 16'hFFFF;
        k.current_ref_input = 16'hFFFF;
        case (c)
            0: k.run = 1'b1;
            1: k.ref_freq_reached = 1'b1;
            2: begin k.accel_ramp = 1'b1; k.output_freq = 16'h0010; end
            3: k.motor_current = 16'h0010;
            4: k.pid_deviation = 16'h0010;
            5: k.drive_fault = 1'b1;
            6: begin k.run = 1'b1; k.current_ref_input = 16'h0000; end
            7: begin k.run = 1'b1; k.pid_fb_diff = 16'sh0005; end
            8: k.comm_watchdog_expired = 1'b1;
            9: k.run = 1'b1;
            10: k.fieldbus_supply_fault = 1'b1;
            default: k.run = 1'b0;
        endcase
        return k;
    endfunction : mk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!(s_bvalid === 1'b1) && n < 50);
        if (n >= 50) begin
            errors++;
            end_of_test();
        end
        rs = s_bresp;
    endtask : wr

    task automatic rdc(input logic [6:0] a, input logic [31:0] e);
        int n;
        n = 0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_arready) s_arvalid <= 1'b0;
        end while (!(s_rvalid === 1'b1) && n < 50);
        if (n >= 50) begin
            errors++;
            end_of_test();
        end
        rd = s_rdata;
        rs = s_rresp;
        chk(rd, e);
    endtask : rdc

    // Apply a core state, let it reach the PLC, compare output 2 or the relay pair
    task automatic see(input sos_core_type k, input logic e);
        core <= k;
        repeat (3) @(posedge aclk);
        chk({31'h0, dout2_q}, {31'h0, e});
    endtask : see

    task automatic rel(input sos_core_type k, input logic [1:0] e);
        core <= k;
        repeat (3) @(posedge aclk);
        chk({30'h0, seen[3:2]}, {30'h0, e});
    endtask : rel

    task automatic t_reset();
        core <= mk(1);
        repeat (3) @(posedge aclk);
        chk({28'h0, seen}, 32'h5);
        rdc(OFS_OUT1_SEL, 32'h1);
        rdc(OFS_OUT2_SEL, 32'h0);
        rdc(OFS_RELAY_SEL, 32'h5);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_codes();
        for (int c = 0; c < 12; c++) begin
            wr(OFS_OUT2_SEL, c);
            see(mk(c % 11), c < 11);
            see(mk(11), 1'b0);
        end
        $display("t_codes done");
    endtask : t_codes

    task automatic t_thresh();
        sos_core_type k;
        k = mk(11);
        wr(OFS_OUT2_SEL, 32'h3);
        wr(OFS_OVL_THR, 32'h10);
        k.motor_current = 16'h0010;
        see(k, 1'b0);
        k.motor_current = 16'h0011;
        see(k, 1'b1);
        k = mk(11);
        k.decel_ramp = 1'b1;
        k.output_freq = 16'h0020;
        wr(OFS_OUT2_SEL, 32'h2);
        wr(OFS_DEC_THR, 32'h20);
        see(k, 1'b0);
        k.output_freq = 16'h0021;
        see(k, 1'b1);
        k = mk(11);
        k.voltage_ref = 16'h00FF;
        wr(OFS_OUT2_SEL, 32'h6);
        wr(OFS_VREF_LOSS, 32'h100);
        see(k, 1'b0);
        k.run = 1'b1;
        see(k, 1'b1);
        k.voltage_ref = 16'h0100;
        see(k, 1'b0);
        k = mk(11);
        k.run = 1'b1;
        k.pid_fb_diff = 16'shFFEF;
        wr(OFS_OUT2_SEL, 32'h7);
        wr(OFS_FB_LOWER, 32'hFFF0);
        see(k, 1'b1);
        k.pid_fb_diff = 16'shFFF0;
        see(k, 1'b0);
        $display("t_thresh done");
    endtask : t_thresh

    task automatic t_logic();
        sos_core_type k;
        logic [2:0] r;
        wr(OFS_OUT2_SEL, 32'h9);
        for (int op = 0; op < 3; op++) begin
            wr(OFS_LOGIC_CFG, 32'h500 | op);
            for (int i = 0; i < 4; i++) begin
                k = mk(11);
                k.run = i[0];
                k.drive_fault = i[1];
                r = {i[0] ^ i[1], i[0] | i[1], i[0] & i[1]};
                see(k, r[op]);
            end
        end
        $display("t_logic done");
    endtask : t_logic

    task automatic t_relay();
        sos_core_type k;
        k = mk(5);
        rel(k, 2'b10);
        rel(mk(11), 2'b01);
        wr(OFS_WD_ACTION, 32'h1);
        rel(mk(8), 2'b10);
        wr(OFS_WD_ACTION, 32'h0);
        rel(mk(8), 2'b01);
        wr(OFS_RELAY_SEL, 32'h0);
        rel(mk(0), 2'b01);
        rel(mk(11), 2'b10);
        wr(OFS_RELAY_SEL, 32'h5);
        k = mk(11);
        k.output_freq = 16'h1234;
        k.motor_current = 16'h0ABC;
        rel(k, 2'b01);
        chk({16'h0, meter}, 32'h1234);
        wr(OFS_METER_SEL, 32'h1);
        rel(k, 2'b01);
        chk({16'h0, meter}, 32'h0ABC);
        $display("t_relay done");
    endtask : t_relay

    task automatic t_irq();
        sos_core_type k;
        core <= mk(11);
        wr(OFS_IRQ_CLR, 32'h3F);
        wr(OFS_IRQ_EN, 32'h2);
        rel(mk(5), 2'b10);
        chk({31'h0, irq_q}, 32'h1);
        wr(OFS_IRQ_CLR, 32'h2);
        k = mk(5);
        k.motor_current = 16'h0020;
        rel(k, 2'b10);
        chk({31'h0, irq_q}, 32'h0);
        rdc(OFS_IRQ_STAT, 32'h1);
        rdc(OFS_COND_STAT, 32'h228);
        rdc(OFS_IRQ_CLR, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        rel(k, 2'b10);
        chk({31'h0, irq_q}, 32'h1);
        wr(7'h44, 32'hFFFF);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        rdc(7'h44, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        $display("t_irq done");
    endtask : t_irq

    task automatic end_of_test();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    initial begin
        #100us;
        errors++;
        end_of_test();
    end

    initial begin
        {aresetn, s_awvalid, s_wvalid, s_arvalid, s_awaddr, s_araddr, s_wdata} = '0;
        core = mk(11);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_codes();
        t_thresh();
        t_logic();
        t_relay();
        t_irq();
        end_of_test();
    end
endmodule : tb_status_output_selector
